//--- logic/opa_pkg.sv
package opa_pkg;

  // ==========================================================
  // register byte offsets on the wishbone slave
  localparam logic [7:0] OFS_REMAP = 8'h00;
  localparam logic [7:0] OFS_MODCTL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // ==========================================================
  // field layout
  localparam int CODE_W = 5;
  localparam int PAIRS = 3;
  localparam int PIN22_CODE_LSB = 0;
  localparam int PIN23_CODE_LSB = 8;
  localparam int PAIR_MODE_LSB = 8;
  localparam int HIGH_EN_LSB = 4;
  localparam int LOW_EN_LSB = 0;
  localparam int ST_HIGH_LSB = 0;
  localparam int ST_LOW_LSB = 4;
  localparam int ST_PIN22_BIT = 8;
  localparam int ST_PIN23_BIT = 9;
  localparam int ST_LARGE_BIT = 10;

  // ==========================================================
  // reset values
  localparam logic [4:0] CODE_RST = 5'h00;
  localparam logic [2:0] PAIR_MODE_RST = 3'h0;
  localparam logic [4:0] CODE_PORT = 5'h00;

  // ==========================================================
  // decoded register select
  typedef enum logic [1:0] {SEL_NONE, SEL_REMAP, SEL_MODCTL, SEL_STATUS} opa_sel_type;

  typedef struct packed {
    logic [4:0] pin22_function_code;
    logic [4:0] pin23_function_code;
    logic [2:0] pair_mode;
    logic [2:0] high_enable;
    logic [2:0] low_enable;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } opa_state_type;

endpackage

//--- logic/opa_ctrl_if.sv
`timescale 1ns/1ps

interface opa_ctrl_if;
  logic [2:0] pair_mode;
  logic [2:0] high_enable;
  logic [2:0] low_enable;
  logic [2:0] mod_high;
  logic [2:0] mod_low;
  logic [2:0] gpio_high_out;
  logic [2:0] gpio_high_oe;
  logic [2:0] gpio_low_out;
  logic [2:0] gpio_low_oe;
  logic [2:0] pin_high_out;
  logic [2:0] pin_high_oe;
  logic [2:0] pin_low_out;
  logic [2:0] pin_low_oe;
  logic [2:0] high_active;
  logic [2:0] low_active;

  modport ctrl (
    output pair_mode, high_enable, low_enable, mod_high, mod_low,
    output gpio_high_out, gpio_high_oe, gpio_low_out, gpio_low_oe,
    input pin_high_out, pin_high_oe, pin_low_out, pin_low_oe, high_active, low_active
  );
  modport route (
    input pair_mode, high_enable, low_enable, mod_high, mod_low,
    input gpio_high_out, gpio_high_oe, gpio_low_out, gpio_low_oe,
    output pin_high_out, pin_high_oe, pin_low_out, pin_low_oe, high_active, low_active
  );
endinterface

//--- logic/opa_pair_route.sv
`timescale 1ns/1ps

module opa_pair_route #(
  parameter bit SECOND_MODULATOR = 1'b0
) (
  opa_ctrl_if.route ctl
);

  // ==========================================================
  // per pair drive selection
  genvar i;
  generate
    for (i = 0; i < opa_pkg::PAIRS; i++)
    begin : g_pair
      logic usable;
      logic low_drive;
      // the second modulator only has its first pair wired out
      assign usable = !(SECOND_MODULATOR && (i > 0));
      assign ctl.high_active[i] = ctl.high_enable[i] & usable;
      assign ctl.low_active[i] = ctl.low_enable[i] & usable;
      // complementary mode: low side is the inverse of the high side
      assign low_drive = ctl.pair_mode[i] ? ctl.mod_low[i] : ~ctl.mod_high[i];
      assign ctl.pin_high_out[i] = ctl.high_active[i] ? ctl.mod_high[i] : ctl.gpio_high_out[i];
      assign ctl.pin_high_oe[i] = ctl.high_active[i] ? 1'b1 : ctl.gpio_high_oe[i];
      assign ctl.pin_low_out[i] = ctl.low_active[i] ? low_drive : ctl.gpio_low_out[i];
      assign ctl.pin_low_oe[i] = ctl.low_active[i] ? 1'b1 : ctl.gpio_low_oe[i];
    end
  endgenerate

endmodule

//--- logic/opa_top.sv
// Function
// - remap register holds pin 23 code in bits 12-8, pin 22 in 4-0, reset zero
// - remap bits 15-13 and 7-5 ignore writes and read zero
// - remap register exists only in the large package variant
// - modulator control holds three pair mode bits at 10-8, reset zero
// - pair mode 1 drives independent outputs, 0 drives complementary outputs
// - pin enable set gives pin to modulator, clear returns it to gpio
// - all pin enable bits reset to the nonvolatile fuse setting
// - second modulator has one pair; other pairs' bits have no effect
`timescale 1ns/1ps

module opa_top #(
  parameter bit LARGE_PACKAGE = 1'b1,
  parameter bit SECOND_MODULATOR = 1'b0
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  input wire logic PIN_ENABLE_DEFAULT_FUSE,
  input wire logic [31:0] PERIPH_FUNC_OUT,
  input wire logic PORT_PIN22_OUT,
  input wire logic PORT_PIN22_OE,
  input wire logic PORT_PIN23_OUT,
  input wire logic PORT_PIN23_OE,
  output logic REMAPPABLE_PIN_22_O,
  output logic REMAPPABLE_PIN_22_OE,
  output logic REMAPPABLE_PIN_23_O,
  output logic REMAPPABLE_PIN_23_OE,
  input wire logic [2:0] MOD_HIGH_IN,
  input wire logic [2:0] MOD_LOW_IN,
  input wire logic [2:0] GPIO_HIGH_OUT,
  input wire logic [2:0] GPIO_HIGH_OE,
  input wire logic [2:0] GPIO_LOW_OUT,
  input wire logic [2:0] GPIO_LOW_OE,
  output logic [2:0] PAIR_HIGH_O,
  output logic [2:0] PAIR_HIGH_OE,
  output logic [2:0] PAIR_LOW_O,
  output logic [2:0] PAIR_LOW_OE
);

  // ==========================================================
  // decode helpers
  function automatic opa_pkg::opa_sel_type decode_addr(input logic [7:0] adr);
    opa_pkg::opa_sel_type sel;
    sel = opa_pkg::SEL_NONE;
    if (adr == opa_pkg::OFS_REMAP && LARGE_PACKAGE)
      sel = opa_pkg::SEL_REMAP;
    else if (adr == opa_pkg::OFS_MODCTL)
      sel = opa_pkg::SEL_MODCTL;
    else if (adr == opa_pkg::OFS_STATUS)
      sel = opa_pkg::SEL_STATUS;
    return sel;
  endfunction

  // only the two low byte lanes hold implemented bits
  function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [31:0] dat,
                                             input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0])
      res[7:0] = dat[7:0];
    if (be[1])
      res[15:8] = dat[15:8];
    return res;
  endfunction

  function automatic logic route_code(input logic [4:0] code, input logic [31:0] func,
                                      input logic port_val);
    logic res;
    res = port_val;
    if (code != opa_pkg::CODE_PORT)
      res = func[code];
    return res;
  endfunction

  // ==========================================================
  // state
  opa_pkg::opa_state_type state_r;
  opa_pkg::opa_state_type state_nxt;
  opa_pkg::opa_sel_type addr_sel;
  logic req;
  logic take;
  logic wr_strobe;
  logic [15:0] remap_image;
  logic [15:0] modctl_image;
  logic [15:0] status_image;
  logic [15:0] remap_new;
  logic [15:0] modctl_new;
  logic pin22_remapped;
  logic pin23_remapped;
  // index 0 stands for pin 22, index 1 for pin 23
  logic [1:0][opa_pkg::CODE_W-1:0] remap_code;
  logic [1:0] port_out;
  logic [1:0] remap_hit;
  logic [1:0] remap_out;

  opa_ctrl_if ctl ();

  assign req = WB_CYC_I & WB_STB_I;
  assign addr_sel = decode_addr(WB_ADR_I);
  // a held strobe is not taken twice: the answer must clear first
  assign take = req & ~state_r.ack & ~state_r.err;
  assign wr_strobe = req & state_r.ack & WB_WE_I;

  // ==========================================================
  // register images as software reads them
  always_comb
  begin
    remap_image = 16'h0000;
    if (LARGE_PACKAGE)
    begin
      remap_image[opa_pkg::PIN22_CODE_LSB +: opa_pkg::CODE_W] = state_r.pin22_function_code;
      remap_image[opa_pkg::PIN23_CODE_LSB +: opa_pkg::CODE_W] = state_r.pin23_function_code;
    end
    modctl_image = 16'h0000;
    modctl_image[opa_pkg::PAIR_MODE_LSB +: opa_pkg::PAIRS] = state_r.pair_mode;
    modctl_image[opa_pkg::HIGH_EN_LSB +: opa_pkg::PAIRS] = state_r.high_enable;
    modctl_image[opa_pkg::LOW_EN_LSB +: opa_pkg::PAIRS] = state_r.low_enable;
    status_image = 16'h0000;
    status_image[opa_pkg::ST_HIGH_LSB +: opa_pkg::PAIRS] = ctl.high_active;
    status_image[opa_pkg::ST_LOW_LSB +: opa_pkg::PAIRS] = ctl.low_active;
    status_image[opa_pkg::ST_PIN22_BIT] = pin22_remapped;
    status_image[opa_pkg::ST_PIN23_BIT] = pin23_remapped;
    status_image[opa_pkg::ST_LARGE_BIT] = LARGE_PACKAGE;
  end

  assign remap_new = merge_lanes(remap_image, WB_DAT_I, WB_SEL_I);
  assign modctl_new = merge_lanes(modctl_image, WB_DAT_I, WB_SEL_I);

  // ==========================================================
  // bus slave and register update
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.ack = 1'b0;
    state_nxt.err = 1'b0;
    // answer one cycle after the request, drop it the cycle after
    if (take)
    begin
      state_nxt.rdata = 32'h0000_0000;
      unique case (addr_sel)
        opa_pkg::SEL_NONE:
          state_nxt.err = 1'b1;
        opa_pkg::SEL_REMAP:
        begin
          state_nxt.ack = 1'b1;
          state_nxt.rdata = {16'h0000, remap_image};
        end
        opa_pkg::SEL_MODCTL:
        begin
          state_nxt.ack = 1'b1;
          state_nxt.rdata = {16'h0000, modctl_image};
        end
        opa_pkg::SEL_STATUS:
        begin
          state_nxt.ack = 1'b1;
          state_nxt.rdata = {16'h0000, status_image};
        end
      endcase
    end
    // writes land on the edge where the master sees ack
    if (wr_strobe)
    begin
      unique case (addr_sel)
        opa_pkg::SEL_REMAP:
        begin
          state_nxt.pin22_function_code = remap_new[opa_pkg::PIN22_CODE_LSB +: opa_pkg::CODE_W];
          state_nxt.pin23_function_code = remap_new[opa_pkg::PIN23_CODE_LSB +: opa_pkg::CODE_W];
        end
        opa_pkg::SEL_MODCTL:
        begin
          state_nxt.pair_mode = modctl_new[opa_pkg::PAIR_MODE_LSB +: opa_pkg::PAIRS];
          state_nxt.high_enable = modctl_new[opa_pkg::HIGH_EN_LSB +: opa_pkg::PAIRS];
          state_nxt.low_enable = modctl_new[opa_pkg::LOW_EN_LSB +: opa_pkg::PAIRS];
        end
        opa_pkg::SEL_STATUS,
        opa_pkg::SEL_NONE:
          state_nxt.rdata = state_r.rdata;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      state_r.pin22_function_code <= opa_pkg::CODE_RST;
      state_r.pin23_function_code <= opa_pkg::CODE_RST;
      state_r.pair_mode <= opa_pkg::PAIR_MODE_RST;
      // fuse is a static strap; a synchronous reset may load it
      state_r.high_enable <= {opa_pkg::PAIRS{PIN_ENABLE_DEFAULT_FUSE}};
      state_r.low_enable <= {opa_pkg::PAIRS{PIN_ENABLE_DEFAULT_FUSE}};
      state_r.ack <= 1'b0;
      state_r.err <= 1'b0;
      state_r.rdata <= 32'h0000_0000;
    end
    else
      state_r <= state_nxt;
  end

  assign WB_ACK_O = state_r.ack;
  assign WB_ERR_O = state_r.err;
  assign WB_DAT_O = state_r.rdata;

  // ==========================================================
  // remappable pins; direction stays with the port logic
  assign remap_code[0] = state_r.pin22_function_code;
  assign remap_code[1] = state_r.pin23_function_code;
  assign port_out[0] = PORT_PIN22_OUT;
  assign port_out[1] = PORT_PIN23_OUT;

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_remap
      // without the remap register the port logic always keeps the pin
      assign remap_hit[p] = LARGE_PACKAGE && (remap_code[p] != opa_pkg::CODE_PORT);
      assign remap_out[p] = remap_hit[p] ?
        route_code(remap_code[p], PERIPH_FUNC_OUT, port_out[p]) : port_out[p];
    end
  endgenerate

  assign pin22_remapped = remap_hit[0];
  assign pin23_remapped = remap_hit[1];
  assign REMAPPABLE_PIN_22_O = remap_out[0];
  assign REMAPPABLE_PIN_23_O = remap_out[1];
  // remap moves only data; a pin set as input stays an input
  assign REMAPPABLE_PIN_22_OE = PORT_PIN22_OE;
  assign REMAPPABLE_PIN_23_OE = PORT_PIN23_OE;

  // ==========================================================
  // modulator pair pins
  assign ctl.pair_mode = state_r.pair_mode;
  assign ctl.high_enable = state_r.high_enable;
  assign ctl.low_enable = state_r.low_enable;
  assign ctl.mod_high = MOD_HIGH_IN;
  assign ctl.mod_low = MOD_LOW_IN;
  assign ctl.gpio_high_out = GPIO_HIGH_OUT;
  assign ctl.gpio_high_oe = GPIO_HIGH_OE;
  assign ctl.gpio_low_out = GPIO_LOW_OUT;
  assign ctl.gpio_low_oe = GPIO_LOW_OE;

  opa_pair_route #(
    .SECOND_MODULATOR(SECOND_MODULATOR)
  ) u_route (
    .ctl(ctl.route)
  );

  assign PAIR_HIGH_O = ctl.pin_high_out;
  assign PAIR_HIGH_OE = ctl.pin_high_oe;
  assign PAIR_LOW_O = ctl.pin_low_out;
  assign PAIR_LOW_OE = ctl.pin_low_oe;

endmodule

//--- sim/opa_top_sva.sv
`timescale 1ns/1ps
// ==========================================================
// bus timing and pin mux checks
module opa_top_sva #(
  parameter bit LARGE_PACKAGE = 1'b1,
  parameter bit SECOND_MODULATOR = 1'b0
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input logic [31:0] WB_DAT_O,
  input logic WB_ACK_O,
  input logic WB_ERR_O,
  input wire logic PORT_PIN22_OE,
  input logic REMAPPABLE_PIN_22_OE,
  input wire logic [2:0] MOD_HIGH_IN,
  input wire logic [2:0] MOD_LOW_IN,
  input wire logic [2:0] GPIO_HIGH_OUT,
  input wire logic [2:0] GPIO_HIGH_OE,
  input wire logic [2:0] GPIO_LOW_OUT,
  input wire logic [2:0] GPIO_LOW_OE,
  input logic [2:0] PAIR_HIGH_O,
  input logic [2:0] PAIR_HIGH_OE,
  input logic [2:0] PAIR_LOW_O,
  input logic [2:0] PAIR_LOW_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic bad_adr;
  // a missing remap register must answer like any hole in the map
  assign bad_adr = !(WB_ADR_I inside {opa_pkg::OFS_REMAP, opa_pkg::OFS_MODCTL, opa_pkg::OFS_STATUS})
    || (WB_ADR_I == opa_pkg::OFS_REMAP && !LARGE_PACKAGE);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  endsequence
  chk_answer_once: assert property ((WB_ACK_O || WB_ERR_O) |=> !WB_ACK_O && !WB_ERR_O) else $error("answer too long");
  chk_answer_next: assert property (s_req |=> WB_ACK_O != WB_ERR_O) else $error("no single answer");
  chk_hole_err: assert property ((s_req ##0 bad_adr) |=> WB_ERR_O) else $error("hole not refused");
  chk_remap_rsvd: assert property ((s_req ##0 (!WB_WE_I && WB_ADR_I == opa_pkg::OFS_REMAP)) |=>
    WB_DAT_O[31:13] == 19'h0 && WB_DAT_O[7:5] == 3'h0) else $error("remap reserved bits set");
  chk_modctl_rsvd: assert property ((s_req ##0 (!WB_WE_I && WB_ADR_I == opa_pkg::OFS_MODCTL)) |=>
    WB_DAT_O[31:11] == 21'h0 && !WB_DAT_O[7] && !WB_DAT_O[3]) else $error("control reserved bits set");
  chk_high_mux: assert property (&((PAIR_HIGH_OE & (PAIR_HIGH_O ~^ MOD_HIGH_IN)) |
    ((PAIR_HIGH_O ~^ GPIO_HIGH_OUT) & (PAIR_HIGH_OE ~^ GPIO_HIGH_OE)))) else $error("high pin source");
  chk_low_mux: assert property (&((PAIR_LOW_OE & ((PAIR_LOW_O ~^ MOD_LOW_IN) | (PAIR_LOW_O ^ MOD_HIGH_IN))) |
    ((PAIR_LOW_O ~^ GPIO_LOW_OUT) & (PAIR_LOW_OE ~^ GPIO_LOW_OE)))) else $error("low pin source");
  chk_remap_oe: assert property (REMAPPABLE_PIN_22_OE == PORT_PIN22_OE) else $error("remap changed direction");
  chk_second_pair: assert property (SECOND_MODULATOR |-> PAIR_HIGH_O[2:1] == GPIO_HIGH_OUT[2:1]
    && PAIR_LOW_OE[2:1] == GPIO_LOW_OE[2:1]) else $error("unused pair drives pin");
endmodule

bind opa_top opa_top_sva #(.LARGE_PACKAGE(LARGE_PACKAGE), .SECOND_MODULATOR(SECOND_MODULATOR)) i_opa_top_sva (
  .CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .PORT_PIN22_OE(PORT_PIN22_OE),
  .REMAPPABLE_PIN_22_OE(REMAPPABLE_PIN_22_OE), .MOD_HIGH_IN(MOD_HIGH_IN), .MOD_LOW_IN(MOD_LOW_IN),
  .GPIO_HIGH_OUT(GPIO_HIGH_OUT), .GPIO_HIGH_OE(GPIO_HIGH_OE), .GPIO_LOW_OUT(GPIO_LOW_OUT),
  .GPIO_LOW_OE(GPIO_LOW_OE), .PAIR_HIGH_O(PAIR_HIGH_O), .PAIR_HIGH_OE(PAIR_HIGH_OE), .PAIR_LOW_O(PAIR_LOW_O),
  .PAIR_LOW_OE(PAIR_LOW_OE));

//--- sim/tb.sv
`timescale 1ns/1ps
// ==========================================================
// bench
module tb;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fuse = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, prt = 4'h0;
  logic [31:0] dat = 32'h0, per = 32'h0, q, a, b, dato;
  logic [2:0] mh = 3'h0, ml = 3'h0, gho = 3'h0, ghe = 3'h0, glo = 3'h0, gle = 3'h0, pho, phe, plo, ple;
  logic ack, err, e, r22, r22e, r23, r23e;
  logic [15:0] rem, mc;
  logic [31:0] q2, s_dat;
  logic [2:0] s_pho, s_phe, s_plo, s_ple;
  logic e2, s_err, s_r22, s_r22e, s_r23, s_r23e;
  int err_total = 0, tests_run = 0;
  always #10 clk = ~clk;
  opa_top #(.LARGE_PACKAGE(1'b1), .SECOND_MODULATOR(1'b0)) i_opa_top (.CLK(clk), .RSTN(rst_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dato), .WB_ACK_O(ack), .WB_ERR_O(err), .PIN_ENABLE_DEFAULT_FUSE(fuse), .PERIPH_FUNC_OUT(per),
    .PORT_PIN22_OUT(prt[0]), .PORT_PIN22_OE(prt[1]), .PORT_PIN23_OUT(prt[2]), .PORT_PIN23_OE(prt[3]),
    .REMAPPABLE_PIN_22_O(r22), .REMAPPABLE_PIN_22_OE(r22e), .REMAPPABLE_PIN_23_O(r23), .REMAPPABLE_PIN_23_OE(r23e),
    .MOD_HIGH_IN(mh), .MOD_LOW_IN(ml), .GPIO_HIGH_OUT(gho), .GPIO_HIGH_OE(ghe), .GPIO_LOW_OUT(glo),
    .GPIO_LOW_OE(gle), .PAIR_HIGH_O(pho), .PAIR_HIGH_OE(phe), .PAIR_LOW_O(plo), .PAIR_LOW_OE(ple));
  // small package with the second modulator, on the same bus and pin inputs
  if (1'b1)
  begin : g_small
    opa_top #(.LARGE_PACKAGE(1'b0), .SECOND_MODULATOR(1'b1)) i_opa_top (.CLK(clk), .RSTN(rst_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
      .WB_DAT_O(s_dat), .WB_ACK_O(), .WB_ERR_O(s_err), .PIN_ENABLE_DEFAULT_FUSE(fuse), .PERIPH_FUNC_OUT(per),
      .PORT_PIN22_OUT(prt[0]), .PORT_PIN22_OE(prt[1]), .PORT_PIN23_OUT(prt[2]), .PORT_PIN23_OE(prt[3]),
      .REMAPPABLE_PIN_22_O(s_r22), .REMAPPABLE_PIN_22_OE(s_r22e), .REMAPPABLE_PIN_23_O(s_r23),
      .REMAPPABLE_PIN_23_OE(s_r23e), .MOD_HIGH_IN(mh), .MOD_LOW_IN(ml), .GPIO_HIGH_OUT(gho), .GPIO_HIGH_OE(ghe),
      .GPIO_LOW_OUT(glo), .GPIO_LOW_OE(gle), .PAIR_HIGH_O(s_pho), .PAIR_HIGH_OE(s_phe), .PAIR_LOW_O(s_plo),
      .PAIR_LOW_OE(s_ple));
  end
  task automatic end_of_test;
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_pin(input logic [15:0] g, input logic [15:0] x);
    tests_run++;
    if (g !== x)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_err(input logic g, input logic x);
    tests_run++;
    if (g !== x)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  // read data and error are taken at the very edge that samples the answer
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, ad, d, s};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    q = dato;
    e = err;
    q2 = s_dat;
    e2 = s_err;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1 && err !== 1'b1)
    begin
      err_total++;
      end_of_test;
    end
  endtask
  task automatic rst(input logic f);
    rst_n <= 1'b0;
    fuse <= f;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  function automatic logic [11:0] pins(input logic [15:0] m);
    logic [2:0] lo;
    lo = (m[10:8] & ml) | (~m[10:8] & ~mh);
    return {(m[6:4] & mh) | (~m[6:4] & gho), m[6:4] | ghe, (m[2:0] & lo) | (~m[2:0] & glo), m[2:0] | gle};
  endfunction
  function automatic logic rp(input logic [4:0] c, input logic po);
    return (c != 5'h00) ? per[c] : po;
  endfunction
  function automatic logic [31:0] stat(input logic [15:0] r, input logic [15:0] m, input logic big);
    return {21'h0, big, big & (|r[12:8]), big & (|r[4:0]), 1'b0, m[2:0], 1'b0, m[6:4]};
  endfunction
  initial
  begin
    void'($urandom(90));
    rst(1'b1);
    wb(1'b0, opa_pkg::OFS_MODCTL, 32'h0, 4'hf);
    cmp(q, 32'h0000_0077);
    wb(1'b0, opa_pkg::OFS_REMAP, 32'h0, 4'hf);
    cmp(q, 32'h0);
    rst(1'b0);
    wb(1'b0, opa_pkg::OFS_MODCTL, 32'h0, 4'hf);
    cmp(q, 32'h0);
    for (int i = 0; i < 30; i++)
    begin
      a = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff_ff01 : $urandom();
      b = $urandom();
      wb(1'b1, opa_pkg::OFS_REMAP, a, 4'h3);
      wb(1'b1, opa_pkg::OFS_MODCTL, b, 4'h3);
      rem = a[15:0] & 16'h1f1f;
      mc = b[15:0] & 16'h0777;
      wb(1'b0, opa_pkg::OFS_REMAP, 32'h0, 4'hf);
      cmp(q, {16'h0, rem});
      cmp_err(e2, 1'b1);
      wb(1'b0, opa_pkg::OFS_MODCTL, 32'h0, 4'hf);
      cmp(q, {16'h0, mc});
      cmp(q2, {16'h0, mc});
      wb(1'b0, opa_pkg::OFS_STATUS, 32'h0, 4'hf);
      cmp(q, stat(rem, mc, 1'b1));
      cmp(q2, stat(rem, mc & 16'h0011, 1'b0));
      @(posedge clk);
      {per, prt, mh, ml, gho, ghe, glo, gle} <= 54'({$urandom(), $urandom()});
      @(posedge clk);
      cmp_pin({4'h0, pho, phe, plo, ple}, {4'h0, pins(mc)});
      cmp_pin({4'h0, s_pho, s_phe, s_plo, s_ple}, {4'h0, pins(mc & 16'h0711)});
      cmp_pin({12'h0, r22, r22e, r23, r23e},
        {12'h0, rp(rem[4:0], prt[0]), prt[1], rp(rem[12:8], prt[2]), prt[3]});
      cmp_pin({12'h0, s_r22, s_r22e, s_r23, s_r23e}, {12'h0, prt[0], prt[1], prt[2], prt[3]});
    end
    // single byte lanes must leave the other byte alone
    wb(1'b1, opa_pkg::OFS_REMAP, 32'h0000_1f1f, 4'h3);
    wb(1'b1, opa_pkg::OFS_REMAP, 32'h0000_0a0a, 4'h2);
    wb(1'b1, opa_pkg::OFS_REMAP, 32'h0000_ffe3, 4'h1);
    wb(1'b1, 8'h0c, 32'hffff_ffff, 4'hf);
    cmp_err(e, 1'b1);
    wb(1'b0, opa_pkg::OFS_REMAP, 32'h0, 4'hf);
    cmp(q, 32'h0000_0a03);
    wb(1'b1, opa_pkg::OFS_MODCTL, 32'h0000_ffff, 4'h2);
    wb(1'b0, opa_pkg::OFS_MODCTL, 32'h0, 4'hf);
    cmp(q, {16'h0, 8'h07, mc[7:0]});
    cmp_pin({4'h0, pho, phe, plo, ple}, {4'h0, pins({8'h07, mc[7:0]})});
    cmp_pin({4'h0, s_pho, s_phe, s_plo, s_ple}, {4'h0, pins({8'h07, mc[7:0]} & 16'h0711)});
    end_of_test;
  end
endmodule
